// File: dv/tb_top.sv
// self-checking bench for the instruction pointer and processor state word block
// assumes zero or more apb wait states and one-cycle event pulses
`default_nettype none
`define CHK(nm, e, g) chk(nm, 32'(e), 32'(g))
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] OFF_IP = 32'(psw_pkg::PSW_OFF_IP); // pointer, read only
    localparam logic [31:0] OFF_ST = 32'(psw_pkg::PSW_OFF_STATE); // state word
    localparam logic [31:0] OFF_STEP = 32'(psw_pkg::PSW_OFF_STEP); // advance pointer
    localparam logic [31:0] OFF_LD = 32'(psw_pkg::PSW_OFF_LOAD); // load pointer
    localparam logic [14:0] P_INSN = 15'h4000, P_FRAME = 15'h2000, P_RET = 15'h1000;
    localparam logic [14:0] P_CTX = 15'h0800, P_SRET = 15'h0400, P_CARRY = 15'h0300;
    // per event: flag bit, trap enable bit, trap output index
    localparam int EVB [8] = '{30, 29, 22, 21, 19, 18, 17, 16};
    localparam int ENB [8] = '{28, 20, 28, 20, 14, 15, 15, 15};
    localparam int TRI [8] = '{0, 1, 0, 1, 3, 2, 2, 2};
    // pointer load value and expected value after one advance
    localparam logic [31:0] IPS [4] = '{32'h8000_0001, 32'hffff_fffe, 32'h7fff_fffe, 32'h1fff_fff0};
    localparam logic [31:0] IPE [4] = '{32'h8000_0002, 32'h8000_0000, 32'h6000_0000, 32'h1fff_fff2};
    // return cases: {context op, ring zero, stacked kind, fault expected}
    localparam logic [4:0] RT [7] = '{5'b01001, 5'b01010, 5'b00100, 5'b01110, 5'b11000, 5'b10001, 5'b11101};
    logic pclk = 1'b0; // 200 mhz clock
    logic presetn = 1'b0; // reset, active low
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [14:0] pv = '0; // one bit per strobe or event input
    logic [1:0] knd = 2'h0; // drives frame kind and stacked kind alike
    logic ring0 = 1'b1; // current ring is zero
    logic cval = 1'b0; // carry or compare value for both datapaths
    wire logic [31:0] prdata;
    wire logic pready, pslverr, int_trap, zdiv_trap, fp_trap, under_trap, trace_trap;
    wire logic in_order, ieee_mode, flush_under_zero, ret_fault;
    wire logic [1:0] unwind_kind;
    wire logic [3:0] traps = {under_trap, fp_trap, zdiv_trap, int_trap}; // trap levels side by side
    int mismatches = 0;
    int n_compared = 0;
    logic [31:0] rd; // read data of the last transfer
    logic err; // error response of the last transfer
    logic [1:0] uw; // last kind a good return used
    logic [4:0] r;
    logic [31:0] ex; // expected word of the sticky check

    always #2.5 pclk = ~pclk;

    psw_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .insn_done(pv[14]), .frame_ev(pv[13]), .ret_req(pv[12]), .ctx_ret_req(pv[11]),
        .step_ret(pv[10]), .a_carry_ev(pv[9]), .d_carry_ev(pv[8]), .a_carry_val(cval),
        .d_carry_val(cval), .a_wrap_ev(pv[0]), .a_zdiv_ev(pv[1]), .d_wrap_ev(pv[2]),
        .d_zdiv_ev(pv[3]), .fp_under_ev(pv[4]), .fp_over_ev(pv[5]), .fp_bad_ev(pv[6]),
        .fp_zdiv_ev(pv[7]), .frame_kind(knd), .stacked_kind(knd), .cur_ring_zero(ring0),
        .int_trap(int_trap), .zdiv_trap(zdiv_trap), .fp_trap(fp_trap), .under_trap(under_trap),
        .trace_trap(trace_trap), .in_order(in_order), .ieee_mode(ieee_mode),
        .flush_under_zero(flush_under_zero), .ret_fault(ret_fault), .unwind_kind(unwind_kind));

    // four-state compare, so an unknown never passes
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic finish_test;
        $display("mismatches %0d compared %0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    // one apb transfer; the leading edge keeps two transfers from touching psel in one step
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            mismatches++;
            $display("BAD pready expected 1 seen %b", pready);
            finish_test();
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        #1;
    endtask : wr

    task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(nm, e, rd);
    endtask : rdc

    // raise the chosen inputs for exactly one cycle, then let that edge settle
    task automatic pulse(input logic [14:0] p);
        @(posedge pclk);
        pv <= p;
        @(posedge pclk);
        pv <= '0;
        #1;
    endtask : pulse

    initial begin
        uw = 2'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rdc("ip reset", OFF_IP, psw_pkg::PSW_RST_IP);
        rdc("psw reset", OFF_ST, psw_pkg::PSW_RST_STATE);
        `CHK("flush zero", 1, flush_under_zero);
        // pointer advance spans, by register write and by a retired instruction
        for (int i = 0; i < 4; i++) begin
            wr(OFF_LD, IPS[i]);
            wr(OFF_IP, 32'h5555_5555); // read-only place, must be ignored
            if (i == 3) pulse(P_INSN);
            else wr(OFF_STEP, 32'h0);
            rdc("ip step", OFF_IP, IPE[i]);
        end
        // unmapped address answers with an error and reads zero
        apb(1'b1, 32'h10, 32'hffff_ffff);
        `CHK("slverr wr", 1, err);
        apb(1'b0, 32'h10, 32'h0);
        `CHK("slverr rd", 1, err);
        `CHK("unmapped rd", 0, rd);
        wr(OFF_ST, 32'hffff_ffff);
        rdc("used bits", OFF_ST, psw_pkg::PSW_USED_MASK);
        wr(OFF_ST, 32'h0);
        // each sticky flag, its survival of later arithmetic, and its trap gate
        for (int i = 0; i < 8; i++) begin
            pulse(15'h1 << i);
            `CHK("trap gated", 0, traps);
            @(posedge pclk);
            cval <= i[0];
            pulse(P_CARRY);
            ex = (32'h1 << EVB[i]) | (i[0] ? 32'h8080_0000 : 32'h0);
            rdc("sticky", OFF_ST, ex);
            // enable only: the write clears the flag, the next event raises the trap
            wr(OFF_ST, 32'h1 << ENB[i]);
            `CHK("trap idle", 0, traps);
            pulse(15'h1 << i);
            `CHK("trap on", 32'h1 << TRI[i], traps);
            wr(OFF_ST, 32'h0);
            `CHK("trap off", 0, traps);
            rdc("cleared", OFF_ST, 32'h0);
        end
        // a zero carry event overrides a written one
        wr(OFF_ST, 32'h8080_0000);
        @(posedge pclk);
        cval <= 1'b0;
        pulse(P_CARRY);
        rdc("carry clear", OFF_ST, 32'h0);
        wr(OFF_ST, 32'h0100_2000);
        `CHK("in order", 1, in_order);
        `CHK("ieee", 1, ieee_mode);
        wr(OFF_ST, 32'h0);
        `CHK("pipelined", 0, in_order);
        `CHK("native", 0, ieee_mode);
        // trace: one trap, none again until the handler returns
        wr(OFF_ST, 32'h0900_0000);
        pulse(P_INSN);
        `CHK("trace", 1, trace_trap);
        @(posedge pclk);
        #1;
        `CHK("trace one cycle", 0, trace_trap);
        pulse(P_INSN);
        `CHK("trace held", 0, trace_trap);
        pulse(P_SRET);
        pulse(P_INSN);
        `CHK("trace again", 1, trace_trap);
        wr(OFF_ST, 32'h0);
        for (int k = 0; k < 4; k++) begin
            @(posedge pclk);
            knd <= 2'(k);
            pulse(P_FRAME);
            rdc("frame kind", OFF_ST, 32'(k) << 25);
        end
        // returns: a fault leaves the last good unwind kind in place
        for (int j = 0; j < 7; j++) begin
            r = RT[j];
            @(posedge pclk);
            knd <= r[2:1];
            ring0 <= r[3];
            pulse(r[4] ? P_CTX : P_RET);
            `CHK("ret fault", r[0], ret_fault);
            if (!r[0]) uw = r[2:1];
            `CHK("unwind kind", uw, unwind_kind);
        end
        finish_test();
    end
endmodule : tb_top
`default_nettype wire

// File: hw/psw_core.sv
// instruction pointer and processor state word, with apb access
// assumes apb master per the protocol; datapath event inputs are one-cycle pulses
//
// Decided for this implementation: the placing of the registers and the APB register port.
`default_nettype none
module psw_core (
    input wire logic pclk, // 200 mhz clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [31:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic insn_done, // pulse: instruction retired, pointer advances
    input wire logic a_carry_ev, // pulse: address carry/compare update
    input wire logic a_carry_val, // carry or compare result
    input wire logic a_wrap_ev, // pulse: address integer overflow
    input wire logic a_zdiv_ev, // pulse: address zero divisor
    input wire logic d_carry_ev, // pulse: data carry/compare update
    input wire logic d_carry_val, // carry or compare result
    input wire logic d_wrap_ev, // pulse: data integer overflow
    input wire logic d_zdiv_ev, // pulse: data zero divisor
    input wire logic fp_under_ev, // pulse: fp underflow
    input wire logic fp_over_ev, // pulse: fp overflow
    input wire logic fp_bad_ev, // pulse: fp reserved operand / inf / nan
    input wire logic fp_zdiv_ev, // pulse: fp zero divisor
    input wire logic frame_ev, // pulse: call/trap/fault made a frame
    input wire logic [1:0] frame_kind, // kind of that frame
    input wire logic [1:0] stacked_kind, // kind bits of the stacked word at return
    input wire logic cur_ring_zero, // current ring is ring 0
    input wire logic ret_req, // pulse: plain return requested
    input wire logic ctx_ret_req, // pulse: context unwind return requested
    input wire logic step_ret, // pulse: trace handler returned
    output logic int_trap, // integer overflow trap request, level
    output logic zdiv_trap, // zero divisor trap request, level
    output logic fp_trap, // floating-point trap request, level
    output logic under_trap, // underflow trap request, level
    output logic trace_trap, // trace trap pulse after a traced instruction
    output logic in_order, // issue waits for previous completion
    output logic ieee_mode, // floating-point format select
    output logic flush_under_zero, // underflowing results deliver true zero
    output logic ret_fault, // pulse: return with illegal kind or ring
    output logic [1:0] unwind_kind // frame kind used by the last return that did not fault
);
    // processor state
    logic [31:0] ip_r; // instruction pointer
    logic [31:0] psw_r; // state word
    logic [31:0] psw_nxt; // next state word
    logic [31:0] ip_step; // pointer after advance
    logic trace_r; // trace trap pulse
    logic ret_fault_r; // return fault pulse
    logic [1:0] unwind_r; // kind of the last unwind

    // trace sequencing: running, or holding while the handler runs until it returns
    typedef enum logic [1:0] {
        PSW_TR_RUN = 2'b01,
        PSW_TR_HOLD = 2'b10
    } psw_tr_t;
    psw_tr_t tr_st_r;

    psw_ip_step u_step (
        .cur_ip(ip_r),
        .next_ip(ip_step)
    );

    // apb decode
    wire acc = psel && penable;
    wire wr_acc = acc && pwrite;
    wire [3:0] off = paddr[3:0];
    wire hit_ip = (paddr[31:4] == 28'h0) && (off == psw_pkg::PSW_OFF_IP);
    wire hit_state = (paddr[31:4] == 28'h0) && (off == psw_pkg::PSW_OFF_STATE);
    wire hit_step = (paddr[31:4] == 28'h0) && (off == psw_pkg::PSW_OFF_STEP);
    wire hit_load = (paddr[31:4] == 28'h0) && (off == psw_pkg::PSW_OFF_LOAD);
    wire mapped = hit_ip || hit_state || hit_step || hit_load;
    wire wr_state = wr_acc && hit_state;
    wire advance = insn_done || (wr_acc && hit_step);

    // single-cycle slave: no wait states
    assign pready = 1'b1;
    assign pslverr = acc && !mapped;
    assign prdata = !psel ? 32'h0 :
        hit_ip ? {ip_r[31:1], 1'b0} :
        hit_state ? (psw_r & psw_pkg::PSW_USED_MASK) : 32'h0;

    // state word next value; events override the software write so none is lost
    always_comb begin
        psw_nxt = wr_state ? (pwdata & psw_pkg::PSW_USED_MASK) : psw_r;
        if (a_carry_ev) begin
            psw_nxt[psw_pkg::PSW_B_ACARRY] = a_carry_val;
        end
        if (d_carry_ev) begin
            psw_nxt[psw_pkg::PSW_B_DCARRY] = d_carry_val;
        end
        if (a_wrap_ev) begin
            psw_nxt[psw_pkg::PSW_B_AWRAP] = 1'b1;
        end
        if (a_zdiv_ev) begin
            psw_nxt[psw_pkg::PSW_B_AZDIV] = 1'b1;
        end
        if (d_wrap_ev) begin
            psw_nxt[psw_pkg::PSW_B_DWRAP] = 1'b1;
        end
        if (d_zdiv_ev) begin
            psw_nxt[psw_pkg::PSW_B_DZDIV] = 1'b1;
        end
        if (fp_under_ev) begin
            psw_nxt[psw_pkg::PSW_B_FPUNDER] = 1'b1;
        end
        if (fp_over_ev) begin
            psw_nxt[psw_pkg::PSW_B_FPOVER] = 1'b1;
        end
        if (fp_bad_ev) begin
            psw_nxt[psw_pkg::PSW_B_FPBAD] = 1'b1;
        end
        if (fp_zdiv_ev) begin
            psw_nxt[psw_pkg::PSW_B_FPZDIV] = 1'b1;
        end
        if (frame_ev) begin
            psw_nxt[psw_pkg::PSW_B_KIND_HI:psw_pkg::PSW_B_KIND_LO] = frame_kind;
        end
    end

    // state word register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            psw_r <= psw_pkg::PSW_RST_STATE;
        end else begin
            psw_r <= psw_nxt;
        end
    end

    // pointer: software load wins over advance; bit 0 kept clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ip_r <= psw_pkg::PSW_RST_IP;
        end else if (wr_acc && hit_load) begin
            ip_r <= {pwdata[31:1], 1'b0};
        end else if (advance) begin
            ip_r <= ip_step;
        end
    end

    // trap requests from enables and sticky flags
    assign int_trap = psw_r[psw_pkg::PSW_B_IWTRAP] &&
        (psw_r[psw_pkg::PSW_B_DWRAP] || psw_r[psw_pkg::PSW_B_AWRAP]);
    assign zdiv_trap = psw_r[psw_pkg::PSW_B_ZDTRAP] &&
        (psw_r[psw_pkg::PSW_B_DZDIV] || psw_r[psw_pkg::PSW_B_AZDIV]);
    assign fp_trap = psw_r[psw_pkg::PSW_B_FPTRAP] && (psw_r[psw_pkg::PSW_B_FPOVER] ||
        psw_r[psw_pkg::PSW_B_FPBAD] || psw_r[psw_pkg::PSW_B_FPZDIV]);
    assign under_trap = psw_r[psw_pkg::PSW_B_SMTRAP] && psw_r[psw_pkg::PSW_B_FPUNDER];
    assign flush_under_zero = 1'b1; // underflow always yields true zero
    assign ieee_mode = psw_r[psw_pkg::PSW_B_IEEE];
    // tracing only behaves if issue is serialised, so tracing forces it too
    assign in_order = psw_r[psw_pkg::PSW_B_INORDER] || psw_r[psw_pkg::PSW_B_STEP];
    assign trace_trap = trace_r;
    assign ret_fault = ret_fault_r;
    assign unwind_kind = unwind_r;

    // trace: one instruction after the handler returns, then trap again
    wire step_on = psw_r[psw_pkg::PSW_B_STEP];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tr_st_r <= PSW_TR_RUN;
            trace_r <= 1'b0;
        end else begin
            trace_r <= 1'b0;
            unique case (tr_st_r)
                PSW_TR_RUN: begin
                    if (step_on && insn_done) begin
                        trace_r <= 1'b1;
                        tr_st_r <= PSW_TR_HOLD;
                    end
                end
                PSW_TR_HOLD: begin
                    // handler running; resume on its return
                    if (step_ret || !step_on) begin
                        tr_st_r <= PSW_TR_RUN;
                    end
                end
            endcase
        end
    end

    // return checking: context block needs ring 0 and the context return op
    wire ctx_kind = (stacked_kind == psw_pkg::PSW_KIND_CTX);
    wire bad_ret = (ret_req && ctx_kind) ||
        (ctx_ret_req && (!ctx_kind || !cur_ring_zero));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ret_fault_r <= 1'b0;
            unwind_r <= 2'h0;
        end else begin
            ret_fault_r <= bad_ret;
            if ((ret_req || ctx_ret_req) && !bad_ret) begin
                unwind_r <= stacked_kind;
            end
        end
    end

    // checks
    property p_ip_wide;
        @(posedge pclk) disable iff (!presetn)
        (insn_done && !(wr_acc && hit_load) && ip_r[31]) |=> ip_r[31] == $past(ip_r[31]) &&
            ip_r[30:1] == $past(ip_r[30:1]) + 30'h1;
    endproperty
    a_ip_wide: assert property (p_ip_wide) else $error("wide pointer step wrong");

    property p_ip_narrow;
        @(posedge pclk) disable iff (!presetn)
        (insn_done && !(wr_acc && hit_load) && !ip_r[31]) |=> ip_r[31:29] == $past(ip_r[31:29]) &&
            ip_r[28:1] == $past(ip_r[28:1]) + 28'h1;
    endproperty
    a_ip_narrow: assert property (p_ip_narrow) else $error("narrow pointer step wrong");

    property p_ip_lsb;
        @(posedge pclk) disable iff (!presetn)
        psel && !pwrite && hit_ip |-> prdata[0] == 1'b0;
    endproperty
    a_ip_lsb: assert property (p_ip_lsb) else $error("pointer bit 0 not zero");

    property p_acarry;
        @(posedge pclk) disable iff (!presetn)
        a_carry_ev |=> psw_r[31] == $past(a_carry_val);
    endproperty
    a_acarry: assert property (p_acarry) else $error("address carry not taken");

    sequence s_awrap_set;
        a_wrap_ev ##1 psw_r[30];
    endsequence
    property p_awrap;
        @(posedge pclk) disable iff (!presetn)
        a_wrap_ev |-> s_awrap_set;
    endproperty
    a_awrap: assert property (p_awrap) else $error("address overflow flag missed");

    property p_sticky;
        @(posedge pclk) disable iff (!presetn)
        $fell(psw_r[22]) || $fell(psw_r[21]) || $fell(psw_r[19]) || $fell(psw_r[16]) |->
            $past(wr_state);
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag cleared without write");

    property p_int_trap;
        @(posedge pclk) disable iff (!presetn)
        int_trap == (psw_r[28] && (psw_r[22] || psw_r[30]));
    endproperty
    a_int_trap: assert property (p_int_trap) else $error("integer trap mismatch");

    property p_fp_trap;
        @(posedge pclk) disable iff (!presetn)
        (fp_over_ev && psw_r[15] && !wr_state) |=> fp_trap;
    endproperty
    a_fp_trap: assert property (p_fp_trap) else $error("fp trap not raised");

    property p_trace;
        @(posedge pclk) disable iff (!presetn)
        (step_on && insn_done && tr_st_r == PSW_TR_RUN) |=> trace_trap ##1 !trace_trap;
    endproperty
    a_trace: assert property (p_trace) else $error("trace trap not single pulse");

    property p_ctx_ret;
        @(posedge pclk) disable iff (!presetn)
        (ctx_ret_req && !cur_ring_zero) |=> ret_fault;
    endproperty
    a_ctx_ret: assert property (p_ctx_ret) else $error("context return outside ring 0");

    property p_unused;
        @(posedge pclk) disable iff (!presetn)
        psw_r[12:0] == 13'h0;
    endproperty
    a_unused: assert property (p_unused) else $error("unused bits hold data");

    // datapath flags, trap gates, frame record, trace hold and return checks
    property p_azdiv;
        @(posedge pclk) disable iff (!presetn)
        a_zdiv_ev |=> psw_r[psw_pkg::PSW_B_AZDIV];
    endproperty
    a_azdiv: assert property (p_azdiv) else $error("address zero divisor flag missed");
    property p_dcarry;
        @(posedge pclk) disable iff (!presetn)
        d_carry_ev |=> psw_r[psw_pkg::PSW_B_DCARRY] == $past(d_carry_val);
    endproperty
    a_dcarry: assert property (p_dcarry) else $error("data carry not taken");
    property p_dwrap;
        @(posedge pclk) disable iff (!presetn)
        d_wrap_ev |=> psw_r[psw_pkg::PSW_B_DWRAP];
    endproperty
    a_dwrap: assert property (p_dwrap) else $error("data overflow flag missed");
    property p_dzdiv;
        @(posedge pclk) disable iff (!presetn)
        d_zdiv_ev |=> psw_r[psw_pkg::PSW_B_DZDIV];
    endproperty
    a_dzdiv: assert property (p_dzdiv) else $error("data zero divisor flag missed");
    property p_fp_under;
        @(posedge pclk) disable iff (!presetn)
        fp_under_ev |=> psw_r[psw_pkg::PSW_B_FPUNDER];
    endproperty
    a_fp_under: assert property (p_fp_under) else $error("fp underflow flag missed");
    property p_fp_bad;
        @(posedge pclk) disable iff (!presetn)
        fp_bad_ev |=> psw_r[psw_pkg::PSW_B_FPBAD];
    endproperty
    a_fp_bad: assert property (p_fp_bad) else $error("bad operand flag missed");
    property p_fp_zdiv;
        @(posedge pclk) disable iff (!presetn)
        fp_zdiv_ev |=> psw_r[psw_pkg::PSW_B_FPZDIV];
    endproperty
    a_fp_zdiv: assert property (p_fp_zdiv) else $error("fp zero divisor flag missed");
    property p_zdiv_trap;
        @(posedge pclk) disable iff (!presetn)
        (a_zdiv_ev && psw_r[psw_pkg::PSW_B_ZDTRAP] && !wr_state) |=> zdiv_trap;
    endproperty
    a_zdiv_trap: assert property (p_zdiv_trap) else $error("zero divisor trap not raised");
    property p_under_trap;
        @(posedge pclk) disable iff (!presetn)
        (fp_under_ev && psw_r[psw_pkg::PSW_B_SMTRAP] && !wr_state) |=> under_trap;
    endproperty
    a_under_trap: assert property (p_under_trap) else $error("underflow trap not raised");
    property p_frame;
        @(posedge pclk) disable iff (!presetn)
        frame_ev |=> psw_r[psw_pkg::PSW_B_KIND_HI:psw_pkg::PSW_B_KIND_LO] == $past(frame_kind);
    endproperty
    a_frame: assert property (p_frame) else $error("frame kind not recorded");
    property p_trace_hold;
        @(posedge pclk) disable iff (!presetn)
        tr_st_r == PSW_TR_HOLD |=> !trace_trap;
    endproperty
    a_trace_hold: assert property (p_trace_hold) else $error("trace trap while handler runs");
    property p_ret_ok;
        @(posedge pclk) disable iff (!presetn)
        (ret_req && !ctx_ret_req && stacked_kind != psw_pkg::PSW_KIND_CTX) |=>
            !ret_fault && unwind_kind == $past(stacked_kind);
    endproperty
    a_ret_ok: assert property (p_ret_ok) else $error("plain return not unwound");
endmodule : psw_core
`default_nettype wire

// File: hw/psw_ip_step.sv
// next-address adder for the instruction pointer
// assumes the caller registers the result; purely combinational
`default_nettype none
module psw_ip_step (
    input wire logic [31:0] cur_ip, // current pointer
    output logic [31:0] next_ip // pointer of the following instruction
);
    // bit 0 is never used, so the adder works on bit 1 upward
    logic [29:0] wide_sum; // bits 30..1 plus one
    logic [27:0] narrow_sum; // bits 28..1 plus one

    assign wide_sum = cur_ip[30:1] + 30'h1;
    assign narrow_sum = cur_ip[28:1] + 28'h1;

    // carries out of the span are dropped so upper bits hold still
    assign next_ip = cur_ip[psw_pkg::PSW_IP_SEG_BIT]
        ? {cur_ip[31], wide_sum, 1'b0}
        : {cur_ip[31:29], narrow_sum, 1'b0};
endmodule : psw_ip_step
`default_nettype wire

// File: hw/psw_pkg.sv
// package for the instruction pointer and processor state word block
// assumes an apb slave with 32-bit data and byte addresses
`default_nettype none
package psw_pkg;
    // register byte offsets on the apb bus
    localparam logic [3:0] PSW_OFF_IP = 4'h0; // instruction pointer, read only
    localparam logic [3:0] PSW_OFF_STATE = 4'h4; // processor state word, read/write
    localparam logic [3:0] PSW_OFF_STEP = 4'h8; // write any value: advance pointer
    localparam logic [3:0] PSW_OFF_LOAD = 4'hc; // write: load pointer (branch target)
    localparam logic [3:0] PSW_OFF_TRAP = 4'h0; // unused alias guard
    // state word field positions
    localparam int PSW_B_ACARRY = 31;
    localparam int PSW_B_AWRAP = 30;
    localparam int PSW_B_AZDIV = 29;
    localparam int PSW_B_IWTRAP = 28;
    localparam int PSW_B_STEP = 27;
    localparam int PSW_B_KIND_HI = 26;
    localparam int PSW_B_KIND_LO = 25;
    localparam int PSW_B_INORDER = 24;
    localparam int PSW_B_DCARRY = 23;
    localparam int PSW_B_DWRAP = 22;
    localparam int PSW_B_DZDIV = 21;
    localparam int PSW_B_ZDTRAP = 20;
    localparam int PSW_B_FPUNDER = 19;
    localparam int PSW_B_FPOVER = 18;
    localparam int PSW_B_FPBAD = 17;
    localparam int PSW_B_FPZDIV = 16;
    localparam int PSW_B_FPTRAP = 15;
    localparam int PSW_B_SMTRAP = 14;
    localparam int PSW_B_IEEE = 13;
    // bits that hold any function; bits 12..0 are unused
    localparam logic [31:0] PSW_USED_MASK = 32'hffff_e000;
    // reset values
    localparam logic [31:0] PSW_RST_STATE = 32'h0000_0000;
    localparam logic [31:0] PSW_RST_IP = 32'h0000_0000;
    // pointer top bit selects the increment span
    localparam int PSW_IP_SEG_BIT = 31;
    // frame kinds
    typedef enum logic [1:0] {
        PSW_KIND_CTX = 2'h0,
        PSW_KIND_EXT = 2'h1,
        PSW_KIND_LONG = 2'h2,
        PSW_KIND_SHORT = 2'h3
    } psw_kind_t;
endpackage : psw_pkg
`default_nettype wire
